/* File: hdl/flash_array_mem.sv */
`timescale 1ns/100ps
module flash_array_mem #(
  parameter int W = 14,
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic clk_sys, // System clock
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write address
  input wire logic [W-1:0] wr_data, // Write data
  input wire logic [AW-1:0] rd_a_addr, // Read port A address
  output logic [W-1:0] rd_a_data, // Read port A data, registered
  input wire logic [AW-1:0] rd_b_addr, // Read port B address
  output logic [W-1:0] rd_b_data // Read port B data, registered
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
    $error("flash_array_mem: DEPTH does not fit AW");
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_a_data <= mem[rd_a_addr];
    rd_b_data <= mem[rd_b_addr];
  end
endmodule // flash_array_mem

/* File: hdl/flash_self_pkg.sv */
package flash_self_pkg;
  // Program space and vectors
  localparam int PC_W = 15;
  localparam int ADDR_W = 12;
  localparam int WORD_W = 14;
  localparam int IMPL_WORDS = 4096;
  localparam logic [11:0] LAST_WORD = 12'hfff;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] IRQ_VEC = 15'h0004;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam int ADDR_HI_W = 7;
  localparam int WORD_HI_W = 6;

  // Register byte offsets
  localparam logic [4:0] OFS_ADDR_LO = 5'h00;
  localparam logic [4:0] OFS_ADDR_HI = 5'h04;
  localparam logic [4:0] OFS_WORD_LO = 5'h08;
  localparam logic [4:0] OFS_WORD_HI = 5'h0c;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_UNLOCK = 5'h14;
  localparam logic [4:0] OFS_PC = 5'h18;

  // Control register fields
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_ALLOW = 2;
  localparam int CTL_ABORT = 3;
  localparam int CTL_ERASE = 4;
  localparam int CTL_LATCH = 5;
  localparam int CTL_W = 6;

  // Unlock pattern and row size defaults
  localparam logic [7:0] UNLOCK_A = 8'h55;
  localparam logic [7:0] UNLOCK_B = 8'haa;
  localparam int ROW_WORDS = 32;

  // Operation timing
  localparam int CLK_NS = 100;
  localparam int PROG_TIME_NS = 2000000;
  localparam int ERASE_TIME_NS = 2000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;

  // Self-write guard codes and protected region ends
  localparam logic [1:0] GUARD_OFF = 2'h3;
  localparam logic [1:0] GUARD_LOW = 2'h2;
  localparam logic [1:0] GUARD_HALF = 2'h1;
  localparam logic [11:0] GUARD_LOW_END = 12'h1ff;
  localparam logic [11:0] GUARD_HALF_END = 12'h7ff;
  localparam int CFG_LOCK = 0;
  localparam int CFG_GUARD = 1;

  typedef enum logic [1:0] {EXT_READ, EXT_WRITE, EXT_BULK, EXT_CFG} ext_cmd_t;

  typedef struct packed {
    ext_cmd_t cmd;
    logic [14:0] addr;
    logic [13:0] data;
  } ext_req_t;
endpackage

/* File: hdl/flash_self_write_ctrl.sv */
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module flash_self_write_ctrl #(
  parameter int ROW_WORDS = flash_self_pkg::ROW_WORDS,
  parameter logic [7:0] UNLOCK_A = flash_self_pkg::UNLOCK_A,
  parameter logic [7:0] UNLOCK_B = flash_self_pkg::UNLOCK_B,
  parameter int PROG_CYCLES = flash_self_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = flash_self_pkg::ERASE_CYCLES
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic power_on, // Power-up clear, synchronous, active high
  input wire logic [4:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic fetch_next, // Core advances to next word
  input wire logic irq_take, // Core accepts an interrupt
  output logic [14:0] fetch_pc, // Program counter
  output logic [13:0] fetch_word, // Word at fetch_pc
  input wire logic ext_valid, // Programmer request pending
  input wire flash_self_pkg::ext_req_t ext_req, // Programmer request
  output logic ext_ack, // Programmer request done, pulse
  output logic ext_denied, // Last request was refused
  output logic [13:0] ext_rdata // Programmer read data
);
  localparam int RB = $clog2(ROW_WORDS);
  localparam int TMR_MAX = (PROG_CYCLES > ERASE_CYCLES) ? PROG_CYCLES : ERASE_CYCLES;
  localparam int TMR_W = $clog2(TMR_MAX + 1);

  if (ROW_WORDS < 2 || ROW_WORDS > flash_self_pkg::IMPL_WORDS ||
      (ROW_WORDS & (ROW_WORDS - 1)) != 0 || PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_chk
    $error("flash_self_write_ctrl: unsupported row size or timing");
  end

  typedef enum logic [2:0] {S_IDLE, S_READ, S_TIME, S_SWEEP, S_EXT_RD} state_t;
  typedef enum logic [1:0] {OP_ERASE, OP_PROG, OP_BULK, OP_EXTW} op_t;

  function automatic logic guarded(input logic [11:0] a, input logic [1:0] g);
    logic hit;
    hit = 1'b1;
    unique case (g)
      flash_self_pkg::GUARD_OFF: hit = 1'b0;
      flash_self_pkg::GUARD_LOW: hit = (a <= flash_self_pkg::GUARD_LOW_END);
      flash_self_pkg::GUARD_HALF: hit = (a <= flash_self_pkg::GUARD_HALF_END);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  state_t st_r;
  op_t op_r;
  logic [TMR_W-1:0] tmr_r;
  logic [11:0] idx_r;
  logic ack_r;
  logic rd_r, wr_r, allow_r, abort_r, erase_sel_r, latch_sel_r;
  logic [1:0] unlock_r;
  logic [7:0] addr_lo_r;
  logic [6:0] addr_hi_r;
  logic [7:0] word_lo_r;
  logic [5:0] word_hi_r;
  logic lock_r;
  logic [1:0] guard_r;
  logic [14:0] pc_r, pc_nxt;
  logic [13:0] latch_r [ROW_WORDS];
  logic [ROW_WORDS-1:0] latch_vld_r;
  flash_self_pkg::ext_req_t hold_r;
  logic ext_ack_r, ext_denied_r;
  logic [13:0] ext_rdata_r;
  logic [31:0] rdata_r;

  logic [4:0] sel;
  logic wr_fire, start_rd, start_wr, start_ext, ext_refuse, sweep_last, op_done;
  logic ctl_write, unlock_write, armed, self_busy, mem_we;
  logic [11:0] addr12, row_base, mem_waddr, mem_b_addr;
  logic [RB-1:0] idx_row;
  logic [13:0] mem_wdata, mem_a_data, mem_b_data;
  logic [31:0] rd_mux;

  // Avalon slave: every access waits exactly one cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  assign sel = {avs_address[4:2], 2'b00};
  assign wr_fire = avs_write & ack_r & avs_byteenable[0];
  assign ctl_write = wr_fire & (sel == flash_self_pkg::OFS_CTRL);
  assign unlock_write = wr_fire & (sel == flash_self_pkg::OFS_UNLOCK);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (sel)
      flash_self_pkg::OFS_ADDR_LO: rd_mux[7:0] = addr_lo_r;
      flash_self_pkg::OFS_ADDR_HI: rd_mux[6:0] = addr_hi_r;
      flash_self_pkg::OFS_WORD_LO: rd_mux[7:0] = word_lo_r;
      flash_self_pkg::OFS_WORD_HI: rd_mux[5:0] = word_hi_r;
      flash_self_pkg::OFS_CTRL: rd_mux[5:0] = {latch_sel_r, erase_sel_r, abort_r,
                                                allow_r, wr_r, rd_r};
      flash_self_pkg::OFS_UNLOCK: rd_mux = 32'h0000_0000;
      flash_self_pkg::OFS_PC: rd_mux[14:0] = pc_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      rdata_r <= rd_mux;
    end
  end

  // Address wraps into the implemented space
  assign addr12 = {addr_hi_r[3:0], addr_lo_r};
  assign row_base = addr12 & ~12'(ROW_WORDS - 1);
  assign idx_row = idx_r[RB-1:0];
  assign armed = (unlock_r == 2'd2);

  // Sequencer hand-off terms
  assign start_rd = (st_r == S_IDLE) & rd_r;
  assign start_wr = (st_r == S_IDLE) & ~rd_r & wr_r;
  assign start_ext = (st_r == S_IDLE) & ~rd_r & ~wr_r & ext_valid & ~ext_ack_r;
  function automatic logic hold_cmd_is_locked(input flash_self_pkg::ext_cmd_t c);
    return c != flash_self_pkg::EXT_BULK;
  endfunction

  assign ext_refuse = ~lock_r & (hold_cmd_is_locked(ext_req.cmd));
  assign self_busy = (st_r == S_TIME || st_r == S_SWEEP) &&
                     (op_r == OP_ERASE || op_r == OP_PROG);

  always_comb begin
    unique case (op_r)
      OP_BULK: sweep_last = (idx_r == flash_self_pkg::LAST_WORD);
      OP_EXTW: sweep_last = 1'b1;
      default: sweep_last = (idx_row == RB'(ROW_WORDS - 1));
    endcase
  end
  assign op_done = (st_r == S_SWEEP) & sweep_last;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= S_IDLE;
      op_r <= OP_ERASE;
      tmr_r <= '0;
      idx_r <= '0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
          idx_r <= '0;
          if (start_rd) begin
            st_r <= S_READ;
          end else if (start_wr) begin
            op_r <= erase_sel_r ? OP_ERASE : OP_PROG;
            tmr_r <= erase_sel_r ? TMR_W'(ERASE_CYCLES - 1) : TMR_W'(PROG_CYCLES - 1);
            st_r <= S_TIME;
          end else if (start_ext & ~ext_refuse) begin
            if (ext_req.cmd == flash_self_pkg::EXT_READ) begin
              st_r <= S_EXT_RD;
            end else if (ext_req.cmd == flash_self_pkg::EXT_WRITE) begin
              op_r <= OP_EXTW;
              tmr_r <= TMR_W'(PROG_CYCLES - 1);
              st_r <= S_TIME;
            end else if (ext_req.cmd == flash_self_pkg::EXT_BULK) begin
              op_r <= OP_BULK;
              tmr_r <= TMR_W'(ERASE_CYCLES - 1);
              st_r <= S_TIME;
            end
          end
        end
        S_READ: st_r <= S_IDLE;
        S_EXT_RD: st_r <= S_IDLE;
        S_TIME: begin
          if (tmr_r == '0) begin
            st_r <= S_SWEEP;
          end else begin
            tmr_r <= tmr_r - TMR_W'(1);
          end
        end
        S_SWEEP: begin
          if (sweep_last) begin
            st_r <= S_IDLE;
          end else begin
            idx_r <= idx_r + 12'h001;
          end
        end
      endcase
    end
  end

  // Array write port: row erase, partial program, bulk erase, programmer word
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = row_base | {{(12 - RB){1'b0}}, idx_row};
    mem_wdata = flash_self_pkg::ERASED_WORD;
    if (st_r == S_SWEEP) begin
      unique case (op_r)
        OP_ERASE: mem_we = 1'b1;
        OP_PROG: begin
          // Only loaded latches are written; other words of the row stay intact
          mem_we = latch_vld_r[idx_row];
          mem_wdata = latch_r[idx_row];
        end
        OP_BULK: begin
          mem_we = 1'b1;
          mem_waddr = idx_r;
        end
        OP_EXTW: begin
          mem_we = 1'b1;
          mem_waddr = hold_r.addr[11:0];
          mem_wdata = hold_r.data;
        end
      endcase
    end
  end

  assign mem_b_addr = rd_r ? addr12 : ext_req.addr[11:0];

  flash_array_mem #(
    .W(flash_self_pkg::WORD_W),
    .DEPTH(flash_self_pkg::IMPL_WORDS),
    .AW(flash_self_pkg::ADDR_W)
  ) u_array (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_a_addr(pc_nxt[11:0]),
    .rd_a_data(mem_a_data),
    .rd_b_addr(mem_b_addr),
    .rd_b_data(mem_b_data)
  );

  // Control strobes and options
  always_ff @(posedge clk_sys) begin
    if (reset | power_on) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      allow_r <= 1'b0;
      erase_sel_r <= 1'b0;
      latch_sel_r <= 1'b0;
    end else begin
      if (start_rd) begin
        rd_r <= 1'b0;
      end else if (ctl_write & avs_writedata[flash_self_pkg::CTL_RD]) begin
        rd_r <= 1'b1;
      end
      if (op_done & (op_r == OP_ERASE || op_r == OP_PROG)) begin
        wr_r <= 1'b0;
      end else if (ctl_write & avs_writedata[flash_self_pkg::CTL_WR] & allow_r & armed &
                   ~avs_writedata[flash_self_pkg::CTL_LATCH] & ~wr_r &
                   ~guarded(addr12, guard_r)) begin
        wr_r <= 1'b1;
      end
      if (ctl_write) begin
        allow_r <= avs_writedata[flash_self_pkg::CTL_ALLOW];
        erase_sel_r <= avs_writedata[flash_self_pkg::CTL_ERASE];
        latch_sel_r <= avs_writedata[flash_self_pkg::CTL_LATCH];
      end
    end
  end

  // Abort flag survives an ordinary reset; only power-up clears it by itself
  always_ff @(posedge clk_sys) begin
    if (power_on) begin
      abort_r <= 1'b0;
    end else if (reset & self_busy) begin
      abort_r <= 1'b1;
    end else if (ctl_write & ~avs_writedata[flash_self_pkg::CTL_ABORT]) begin
      abort_r <= 1'b0;
    end
  end

  // Two-write unlock; any other register write disarms it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      unlock_r <= 2'd0;
    end else if (unlock_write) begin
      if (avs_writedata[7:0] == UNLOCK_A) begin
        unlock_r <= 2'd1;
      end else if (avs_writedata[7:0] == UNLOCK_B && unlock_r == 2'd1) begin
        unlock_r <= 2'd2;
      end else begin
        unlock_r <= 2'd0;
      end
    end else if (wr_fire) begin
      unlock_r <= 2'd0;
    end
  end

  // Address and data pairs; a finished read overrides a same-cycle bus write to the data pair
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_lo_r <= 8'h00;
      addr_hi_r <= 7'h00;
      word_lo_r <= 8'h00;
      word_hi_r <= 6'h00;
    end else begin
      if (wr_fire & (sel == flash_self_pkg::OFS_ADDR_LO)) begin
        addr_lo_r <= avs_writedata[7:0];
      end
      if (wr_fire & (sel == flash_self_pkg::OFS_ADDR_HI)) begin
        addr_hi_r <= avs_writedata[6:0];
      end
      if (st_r == S_READ) begin
        {word_hi_r, word_lo_r} <= mem_b_data;
      end else begin
        if (wr_fire & (sel == flash_self_pkg::OFS_WORD_LO)) begin
          word_lo_r <= avs_writedata[7:0];
        end
        if (wr_fire & (sel == flash_self_pkg::OFS_WORD_HI)) begin
          word_hi_r <= avs_writedata[5:0];
        end
      end
    end
  end

  // Write latches: unlocked latch-load writes fill them by row index
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_vld_r <= '0;
    end else if (op_done & (op_r == OP_PROG)) begin
      latch_vld_r <= '0;
    end else if (ctl_write & avs_writedata[flash_self_pkg::CTL_WR] &
                 avs_writedata[flash_self_pkg::CTL_LATCH] & allow_r & armed &
                 (st_r == S_IDLE) & ~wr_r) begin
      latch_vld_r[addr12[RB-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ctl_write & avs_writedata[flash_self_pkg::CTL_WR] &
        avs_writedata[flash_self_pkg::CTL_LATCH] & allow_r & armed &
        (st_r == S_IDLE) & ~wr_r) begin
      latch_r[addr12[RB-1:0]] <= {word_hi_r, word_lo_r};
    end
  end

  // Configuration: readout lock and guard, erased state at power-up
  always_ff @(posedge clk_sys) begin
    if (power_on) begin
      lock_r <= 1'b1;
      guard_r <= flash_self_pkg::GUARD_OFF;
    end else if (op_done & (op_r == OP_BULK)) begin
      lock_r <= 1'b1;
      guard_r <= flash_self_pkg::GUARD_OFF;
    end else if (start_ext & ~ext_refuse & (ext_req.cmd == flash_self_pkg::EXT_CFG)) begin
      lock_r <= ext_req.data[flash_self_pkg::CFG_LOCK];
      guard_r <= ext_req.data[flash_self_pkg::CFG_GUARD +: 2];
    end
  end

  // Programmer side; the guard field never gates these paths
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_r <= '0;
      ext_ack_r <= 1'b0;
      ext_denied_r <= 1'b0;
      ext_rdata_r <= 14'h0000;
    end else begin
      ext_ack_r <= 1'b0;
      if (start_ext) begin
        hold_r <= ext_req;
      end
      if (start_ext & ext_refuse) begin
        ext_ack_r <= 1'b1;
        ext_denied_r <= 1'b1;
      end else if (start_ext & (ext_req.cmd == flash_self_pkg::EXT_CFG)) begin
        ext_ack_r <= 1'b1;
        ext_denied_r <= 1'b0;
      end else if (st_r == S_EXT_RD) begin
        ext_ack_r <= 1'b1;
        ext_denied_r <= 1'b0;
        ext_rdata_r <= mem_b_data;
      end else if (op_done & (op_r == OP_EXTW || op_r == OP_BULK)) begin
        ext_ack_r <= 1'b1;
        ext_denied_r <= 1'b0;
      end
    end
  end

  assign ext_ack = ext_ack_r;
  assign ext_denied = ext_denied_r;
  assign ext_rdata = ext_rdata_r;

  // Program counter; array port A looks at the next value so data stay aligned
  always_comb begin
    pc_nxt = pc_r;
    if (irq_take) begin
      pc_nxt = flash_self_pkg::IRQ_VEC;
    end else if (fetch_next) begin
      pc_nxt = pc_r + 15'h0001;
    end
    if (reset) begin
      pc_nxt = flash_self_pkg::RESET_VEC;
    end
  end

  always_ff @(posedge clk_sys) begin
    pc_r <= pc_nxt;
  end

  assign fetch_pc = pc_r;
  assign fetch_word = mem_a_data;
endmodule // flash_self_write_ctrl

/* File: testbench/ext_prog_model.sv */
`timescale 1ns/100ps
module ext_prog_model (
  input wire logic clk_sys, // System clock
  output logic ext_valid, // Request pending
  output flash_self_pkg::ext_req_t ext_req, // Request
  input wire logic ext_ack, // Done pulse
  input wire logic ext_denied, // Refused
  input wire logic [13:0] ext_rdata // Read data
);
  initial begin
    ext_valid = 1'b0;
    ext_req = '0;
  end

  // Released fields show the inverse so a stale request is never mistaken for a live one
  task issue(input flash_self_pkg::ext_cmd_t c, input logic [14:0] a, input logic [13:0] d,
             output logic dn, output logic [13:0] q);
    int n;
    @(posedge clk_sys);
    ext_req <= '{cmd: c, addr: a, data: d};
    ext_valid <= 1'b1;
    n = 0;
    dn = 1'bx;
    q = 'x;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ext_ack !== 1'b1 && n < 6000);
    if (ext_ack === 1'b1) begin
      dn = ext_denied;
      q = ext_rdata;
    end
    ext_valid <= 1'b0;
    ext_req <= ~ext_req;
  endtask
endmodule // ext_prog_model

/* File: testbench/flash_ctrl_asserts.sv */
`timescale 1ns/100ps
module flash_ctrl_asserts (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Sync reset
  input wire logic [4:0] avs_address, // Bus address
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic [31:0] avs_readdata, // Bus read data
  input wire logic avs_waitrequest, // Bus stall
  input wire logic fetch_next, // Core step
  input wire logic irq_take, // Interrupt taken
  input wire logic [14:0] fetch_pc, // Program counter
  input wire logic ext_ack, // Programmer done
  input wire logic ext_denied // Programmer refused
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire take_rd = avs_read && !avs_waitrequest;

  wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised with no request");
  unlock_zero_a: assert property (take_rd && avs_address[4:2] == flash_self_pkg::OFS_UNLOCK[4:2]
    |-> avs_readdata == 32'h0) else $error("unlock register read not zero");
  word_width_a: assert property (take_rd && avs_address[4:2] == flash_self_pkg::OFS_WORD_HI[4:2]
    |-> avs_readdata[31:6] == 26'h0) else $error("word high wider than 6 bits");
  addr_width_a: assert property (take_rd && avs_address[4:2] == flash_self_pkg::OFS_ADDR_HI[4:2]
    |-> avs_readdata[31:7] == 25'h0) else $error("address high wider than 7 bits");
  pc_reset_a: assert property (disable iff (1'b0) reset |=> fetch_pc == flash_self_pkg::RESET_VEC)
    else $error("fetch not at reset vector");
  irq_vec_a: assert property (irq_take |=> fetch_pc == flash_self_pkg::IRQ_VEC)
    else $error("fetch not at interrupt vector");
  pc_step_a: assert property (fetch_next && !irq_take |=> fetch_pc == $past(fetch_pc) + 15'h1)
    else $error("program counter did not step");
  ack_pulse_a: assert property (ext_ack |=> !ext_ack)
    else $error("programmer ack longer than one cycle");
  denied_hold_a: assert property (!ext_ack |-> $stable(ext_denied))
    else $error("refusal changed without ack");
endmodule // flash_ctrl_asserts

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk_sys, reset, power_on, avs_read, avs_write, avs_waitrequest, fetch_next, irq_take;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [3:0] avs_byteenable;
  logic ext_valid, ext_ack, ext_denied, dn;
  logic [14:0] fetch_pc, row;
  logic [13:0] fetch_word, ext_rdata, rd_w, d;
  logic [13:0] model [0:4095];
  flash_self_pkg::ext_req_t ext_req;
  int miscompares = 0;
  int checks_done = 0;
  int k;

  flash_self_write_ctrl #(.PROG_CYCLES(8), .ERASE_CYCLES(8)) i_flash_self_write_ctrl (.clk_sys,
    .reset, .power_on, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .fetch_next, .irq_take, .fetch_pc, .fetch_word,
    .ext_valid, .ext_req, .ext_ack, .ext_denied, .ext_rdata);
  ext_prog_model i_ext_prog_model (.clk_sys, .ext_valid, .ext_req, .ext_ack, .ext_denied,
    .ext_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [7:0] dat);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, dat};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      print_verdict;
    end
  endtask

  task op(input logic [7:0] c);
    bus(1, flash_self_pkg::OFS_UNLOCK, flash_self_pkg::UNLOCK_A);
    bus(1, flash_self_pkg::OFS_UNLOCK, flash_self_pkg::UNLOCK_B);
    bus(1, flash_self_pkg::OFS_CTRL, c);
  endtask

  task seta(input logic [14:0] a);
    bus(1, flash_self_pkg::OFS_ADDR_LO, a[7:0]);
    bus(1, flash_self_pkg::OFS_ADDR_HI, {1'b0, a[14:8]});
  endtask

  // Polls until both strobes have dropped; the bound sits well past one erase
  task waitdone;
    int n;
    n = 0;
    do begin
      bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
      n++;
    end while (v[1:0] !== 2'b00 && n < 100);
    if (n >= 100) begin
      miscompares++;
      print_verdict;
    end
  endtask

  task sread(input logic [14:0] a);
    seta(a);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h05);
    waitdone;
    bus(0, flash_self_pkg::OFS_WORD_LO, 8'h00);
    rd_w[7:0] = v[7:0];
    bus(0, flash_self_pkg::OFS_WORD_HI, 8'h00);
    rd_w[13:8] = v[5:0];
  endtask

  task load(input logic [14:0] a, input logic [13:0] w);
    seta(a);
    bus(1, flash_self_pkg::OFS_WORD_LO, w[7:0]);
    bus(1, flash_self_pkg::OFS_WORD_HI, {2'b0, w[13:8]});
    op(8'h26);
    model[a[11:0]] = w;
  endtask

  task ext(input logic [1:0] c, input logic [14:0] a, input logic [13:0] w);
    i_ext_prog_model.issue(flash_self_pkg::ext_cmd_t'(c), a, w, dn, rd_w);
    // An unanswered request leaves the refusal unknown
    if (dn === 1'bx) begin
      miscompares++;
      print_verdict;
    end
  endtask

  initial begin
    reset = 1'b1;
    power_on = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    fetch_next = 1'b0;
    irq_take = 1'b0;
    void'($urandom(91));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    power_on <= 1'b0;
    @(posedge clk_sys);
    check(fetch_pc, flash_self_pkg::RESET_VEC);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v, 32'h0);
    bus(0, flash_self_pkg::OFS_UNLOCK, 8'h00);
    check(v, 32'h0);
    bus(0, 5'h1c, 8'h00);
    check(v, 32'h0);
    fetch_next <= 1'b1;
    repeat (3) @(posedge clk_sys);
    fetch_next <= 1'b0;
    bus(0, flash_self_pkg::OFS_PC, 8'h00);
    check(v, 32'h3);
    irq_take <= 1'b1;
    @(posedge clk_sys);
    irq_take <= 1'b0;
    bus(0, flash_self_pkg::OFS_PC, 8'h00);
    check(v, flash_self_pkg::IRQ_VEC);
    ext(2, 15'h0, 14'h0);
    check(dn, 1'b0);
    foreach (model[i]) model[i] = flash_self_pkg::ERASED_WORD;
    ext(0, 15'h123, 14'h0);
    check(rd_w, flash_self_pkg::ERASED_WORD);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h04);
    for (int r = 0; r < 3; r++) begin
      row = 15'h800 | (15'($urandom) & 15'h7e0);
      k = 1 + $urandom % 4;
      for (int i = 0; i < k; i++) load(row + 15'(i), 14'($urandom));
      op(8'h06);
      bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
      check(v[1], 1'b1);
      waitdone;
      for (int i = 0; i <= k; i++) begin
        sread(row + 15'(i));
        check(rd_w, model[row[11:0] + 12'(i)]);
      end
    end
    sread(15'h4000 | row);
    check(rd_w, model[row[11:0]]);
    bus(0, flash_self_pkg::OFS_ADDR_HI, 8'h00);
    check(v, 32'h40 | row[14:8]);
    avs_byteenable <= 4'he;
    bus(1, flash_self_pkg::OFS_ADDR_LO, 8'h5a);
    avs_byteenable <= 4'hf;
    bus(0, flash_self_pkg::OFS_ADDR_LO, 8'h00);
    check(v, 32'(row[7:0]));
    load(row + 15'h9, 14'($urandom));
    op(8'h06);
    waitdone;
    sread(row + 15'h9);
    check(rd_w, model[row[11:0] + 12'h9]);
    sread(row);
    check(rd_w, model[row[11:0]]);
    seta(row);
    op(8'h16);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h04);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[1], 1'b1);
    waitdone;
    sread(row + 15'h1f);
    check(rd_w, flash_self_pkg::ERASED_WORD);
    sread(row);
    check(rd_w, flash_self_pkg::ERASED_WORD);
    seta(row);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h06);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[1], 1'b0);
    bus(1, flash_self_pkg::OFS_UNLOCK, flash_self_pkg::UNLOCK_A);
    bus(1, flash_self_pkg::OFS_UNLOCK, flash_self_pkg::UNLOCK_B);
    bus(1, flash_self_pkg::OFS_ADDR_LO, row[7:0]);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h06);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[1], 1'b0);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h00);
    op(8'h02);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[2:1], 2'b00);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h04);
    ext(3, 15'h0, 14'h5);
    seta(15'h040);
    op(8'h16);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[1], 1'b0);
    d = 14'($urandom);
    ext(1, 15'h040, d);
    check(dn, 1'b0);
    ext(0, 15'h040, 14'h0);
    check(rd_w, d);
    fetch_next <= 1'b1;
    repeat (60) @(posedge clk_sys);
    fetch_next <= 1'b0;
    @(posedge clk_sys);
    check(fetch_pc, 15'h040);
    check(fetch_word, d);
    ext(3, 15'h0, 14'h4);
    ext(0, 15'h040, 14'h0);
    check(dn, 1'b1);
    load(row, 14'($urandom));
    op(8'h06);
    waitdone;
    sread(row);
    check(rd_w, model[row[11:0]]);
    seta(row);
    op(8'h16);
    // Let the erase leave idle so the reset lands mid-operation
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[3:0], 4'h8);
    bus(1, flash_self_pkg::OFS_CTRL, 8'h00);
    bus(0, flash_self_pkg::OFS_CTRL, 8'h00);
    check(v[3], 1'b0);
    ext(2, 15'h0, 14'h0);
    check(dn, 1'b0);
    ext(0, row, 14'h0);
    check(rd_w, flash_self_pkg::ERASED_WORD);
    print_verdict;
  end
endmodule // tb

bind flash_self_write_ctrl flash_ctrl_asserts i_flash_ctrl_asserts (.clk_sys, .reset,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .fetch_next,
  .irq_take, .fetch_pc, .ext_ack, .ext_denied);
